// ==== hw/dfv_pkg.sv ====
// Shared constants and types for the digital frame voter: selector and receiver shelf ends.
// Assumes one 125 MHz clock and an asynchronous active-low reset at both ends.
// Functional notes
// - frames are 2152 bits, 112-bit clear header
// - shelf grades header errors against known pattern
// - shelf reports one of ten categories on request
// - one shared serial bus, selector sole master
// - shelf address 0..31 from address switch
// - installer keeps shelf addresses distinct
// - selector serves up to 32 shelves
// - poll valid first, then category
// - one shelf chosen per polling round
// - ties go to lowest polling address
// - chosen frame loads at 19.2 kbaud
// - buffered frames leave serially at 9.6 kbaud
// - next frame chosen before buffer drains
// - silent shelf dropped from poll list
// - reset button rediscovers all shelves
// - digital stream active inhibits analog path
`default_nettype none

package dfv_pkg;
  localparam int CLK_HZ = 125_000_000;
  localparam int BUS_BAUD = 19_200;
  localparam int OUT_BAUD = 9_600;
  localparam int BUS_BIT_CYC = CLK_HZ / BUS_BAUD;
  localparam int OUT_BIT_CYC = CLK_HZ / OUT_BAUD;
  localparam int FRAME_MS = 224;
  localparam int REPLY_WAIT_BITS = 40;
  localparam int WAIT_CYC = REPLY_WAIT_BITS * BUS_BIT_CYC;
  localparam int FRAME_BITS = 2152;
  localparam int HDR_BITS = 112;
  localparam int FRAME_BYTES = FRAME_BITS / 8;
  localparam int HDR_BYTES = HDR_BITS / 8;
  localparam int NUM_CAT = 10;
  localparam int MAX_RX = 32;
  localparam int FIFO_W = 8;
  localparam int FIFO_D = 16;
  localparam int CAT_SHIFT = 1;
  localparam logic [2:0] OP_VALID = 3'h1;
  localparam logic [2:0] OP_CAT = 3'h2;
  localparam logic [2:0] OP_FRAME = 3'h3;
  localparam logic [3:0] CAT_WORST = 4'(NUM_CAT - 1);
  localparam logic [4:0] ADDR_FIRST = 5'h00;
  localparam logic [4:0] ADDR_LAST = 5'(MAX_RX - 1);
  localparam logic [8:0] FRAME_LAST = 9'(FRAME_BYTES - 1);
  localparam logic [8:0] HDR_COUNT = 9'(HDR_BYTES);
  // known header content, arbitrary value
  localparam logic [HDR_BITS-1:0] HDR_PATTERN = 112'h5A3C_96F0_0FE1_2D4B_7788_C3A5_1E69;

  typedef enum logic [4:0] {
    SS_HOLD = 5'h01,
    SS_CMD = 5'h02,
    SS_RSP = 5'h04,
    SS_NEXT = 5'h08,
    SS_LOAD = 5'h10
  } dfv_sel_state_t;

  typedef enum logic [1:0] {
    RS_IDLE = 2'h1,
    RS_STREAM = 2'h2
  } dfv_shelf_state_t;
endpackage

`default_nettype wire

// ==== hw/dfv_bus_if.sv ====
// Shared asynchronous serial bus between selector and one receiver shelf.
// Assumes the bench wire-ANDs the shelf reply lines when it joins several shelves.
`default_nettype none

interface dfv_bus_if;
  logic cmd;
  logic rsp_o;
  logic rsp_oe;
  logic rsp;

  // open-drain reply line idles high
  assign rsp = rsp_oe ? rsp_o : 1'b1;

  modport selector (output cmd, input rsp);
  modport shelf (input cmd, output rsp_o, output rsp_oe);
endinterface

`default_nettype wire

// ==== hw/dfv_selector.sv ====
// Voter selector: polls shelves, buffers chosen frames, plays them out serially.
// Also holds the serial byte transmitter and receiver shared with the shelf end, and the FIFO.
// Assumes one clock domain; bus lines and reset button arrive asynchronously.
`default_nettype none

// ****************************************
// serial byte transmitter, 8N1
// ****************************************
module dfv_uart_tx #(
  parameter int BIT_CYC = 6510
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic start,
  input wire logic [7:0] data,
  output logic busy_ff,
  output logic line_ff,
  output logic low_ff
);
  logic [9:0] sh_ff;
  logic [3:0] bitn_ff;
  logic [15:0] cnt_ff;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sh_ff <= 10'h3FF;
      bitn_ff <= 4'h0;
      cnt_ff <= 16'h0000;
      busy_ff <= 1'b0;
      line_ff <= 1'b1;
      low_ff <= 1'b0;
    end else if (!busy_ff && start) begin
      sh_ff <= {1'b1, data, 1'b0};
      bitn_ff <= 4'h0;
      cnt_ff <= 16'h0000;
      busy_ff <= 1'b1;
      line_ff <= 1'b0;
      low_ff <= 1'b1;
    end else if (busy_ff) begin
      if (cnt_ff == 16'(BIT_CYC - 1)) begin
        cnt_ff <= 16'h0000;
        sh_ff <= {1'b1, sh_ff[9:1]};
        if (bitn_ff == 4'h9) begin
          busy_ff <= 1'b0;
          line_ff <= 1'b1;
          low_ff <= 1'b0;
        end else begin
          bitn_ff <= bitn_ff + 4'h1;
          line_ff <= sh_ff[1];
          low_ff <= ~sh_ff[1];
        end
      end else begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end
endmodule

// ****************************************
// serial byte receiver, 8N1, mid-bit sampling
// ****************************************
module dfv_uart_rx #(
  parameter int BIT_CYC = 6510
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic line,
  output logic valid_ff,
  output logic [7:0] data_ff
);
  logic s1_ff;
  logic s2_ff;
  logic busy_ff;
  logic [3:0] bitn_ff;
  logic [15:0] cnt_ff;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
    end else begin
      s1_ff <= line;
      s2_ff <= s1_ff;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busy_ff <= 1'b0;
      bitn_ff <= 4'h0;
      cnt_ff <= 16'h0000;
      valid_ff <= 1'b0;
      data_ff <= 8'h00;
    end else begin
      valid_ff <= 1'b0;
      if (!busy_ff) begin
        if (!s2_ff) begin
          busy_ff <= 1'b1;
          bitn_ff <= 4'h0;
          cnt_ff <= 16'(BIT_CYC / 2);
        end
      end else if (cnt_ff == 16'(BIT_CYC - 1)) begin
        cnt_ff <= 16'h0000;
        bitn_ff <= bitn_ff + 4'h1;
        if (bitn_ff == 4'h0 && s2_ff) begin
          busy_ff <= 1'b0;
        end else if (bitn_ff == 4'h9) begin
          busy_ff <= 1'b0;
          valid_ff <= s2_ff;
        end else if (bitn_ff != 4'h0) begin
          data_ff <= {s2_ff, data_ff[7:1]};
        end
      end else begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end
endmodule

// ****************************************
// synchronous FIFO
// ****************************************
module dfv_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wp_ff;
  logic [AW:0] rp_ff;

  assign in_ready = (wp_ff - rp_ff) != (AW + 1)'(DEPTH);
  assign out_valid = wp_ff != rp_ff;
  assign out_data = mem[rp_ff[AW-1:0]];

  always_ff @(posedge clock) begin
    if (in_valid && in_ready) begin
      mem[wp_ff[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wp_ff <= '0;
      rp_ff <= '0;
    end else begin
      if (in_valid && in_ready) begin
        wp_ff <= wp_ff + 1'b1;
      end
      if (out_valid && out_ready) begin
        rp_ff <= rp_ff + 1'b1;
      end
    end
  end
endmodule

// ****************************************
// voter selector top
// ****************************************
module dfv_selector import dfv_pkg::*; #(
  parameter int BUS_CYC = BUS_BIT_CYC,
  parameter int OUT_CYC = OUT_BIT_CYC,
  parameter int REPLY_CYC = WAIT_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  dfv_bus_if.selector bus,
  input wire logic reset_button,
  output logic stream_data_ff,
  output logic stream_strobe_ff,
  output logic analog_inhibit_ff,
  output logic [MAX_RX-1:0] active_ff,
  output logic [4:0] chosen_addr_ff
);
  dfv_sel_state_t state_ff;
  logic [2:0] btn_ff;
  logic enum_ff;
  logic found_ff;
  logic [2:0] op_ff;
  logic [4:0] addr_ff;
  logic [3:0] best_cat_ff;
  logic [8:0] ld_cnt_ff;
  logic wr_half_ff;
  logic rd_half_ff;
  logic [8:0] rd_cnt_ff;
  logic [1:0] full_ff;
  logic [19:0] tmr_ff;
  logic [7:0] frame_mem [2][FRAME_BYTES];
  logic btn_rise;
  logic rescan_ff;
  logic skip;
  logic tx_go;
  logic tx_busy;
  logic tx_low;
  logic rx_valid;
  logic [7:0] rx_data;
  logic timeout;
  logic load_last;
  logic push;
  logic rd_last;
  logic f_ready;
  logic f_valid;
  logic [7:0] f_data;
  logic pop;
  logic [7:0] sh_ff;
  logic [3:0] left_ff;
  logic [15:0] bit_cnt_ff;
  logic tick;

  // ****************************************
  // bus master
  // ****************************************
  assign btn_rise = btn_ff[1] & ~btn_ff[2];
  assign skip = !enum_ff && op_ff == OP_VALID && !active_ff[addr_ff];
  assign tx_go = state_ff == SS_CMD && !tx_busy && !skip;
  assign timeout = tmr_ff == 20'(REPLY_CYC - 1);
  assign load_last = state_ff == SS_LOAD && rx_valid && ld_cnt_ff == FRAME_LAST;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      btn_ff <= 3'h0;
    end else begin
      btn_ff <= {btn_ff[1:0], reset_button};
    end
  end

  // rescan waits for an idle bus, so a shelf still streaming or replying is not taken as a scan reply
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rescan_ff <= 1'b0;
    end else if (btn_rise) begin
      rescan_ff <= 1'b1;
    end else if (state_ff == SS_HOLD) begin
      rescan_ff <= 1'b0;
    end
  end

  dfv_uart_tx #(.BIT_CYC(BUS_CYC)) u_tx (
    .clock(clock), .rstn(rstn), .start(tx_go), .data({op_ff, addr_ff}),
    .busy_ff(tx_busy), .line_ff(bus.cmd), .low_ff(tx_low)
  );

  dfv_uart_rx #(.BIT_CYC(BUS_CYC)) u_rx (
    .clock(clock), .rstn(rstn), .line(bus.rsp), .valid_ff(rx_valid), .data_ff(rx_data)
  );

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tmr_ff <= 20'h00000;
    end else if ((state_ff == SS_RSP || state_ff == SS_LOAD) && !rx_valid) begin
      tmr_ff <= tmr_ff + 20'h00001;
    end else begin
      tmr_ff <= 20'h00000;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= SS_HOLD;
      enum_ff <= 1'b1;
      active_ff <= '0;
      found_ff <= 1'b0;
      op_ff <= OP_VALID;
      addr_ff <= ADDR_FIRST;
      best_cat_ff <= CAT_WORST;
      chosen_addr_ff <= ADDR_FIRST;
      ld_cnt_ff <= 9'h000;
      wr_half_ff <= 1'b0;
    end else if (rescan_ff && state_ff == SS_HOLD) begin
      state_ff <= SS_HOLD;
      enum_ff <= 1'b1;
      active_ff <= '0;
    end else begin
      unique case (state_ff)
        SS_HOLD: begin
          if (!full_ff[wr_half_ff]) begin
            state_ff <= SS_CMD;
            op_ff <= OP_VALID;
            addr_ff <= ADDR_FIRST;
            found_ff <= 1'b0;
            best_cat_ff <= CAT_WORST;
          end
        end
        SS_CMD: begin
          ld_cnt_ff <= 9'h000;
          if (skip) begin
            state_ff <= SS_NEXT;
          end else if (!tx_busy) begin
            state_ff <= (op_ff == OP_FRAME) ? SS_LOAD : SS_RSP;
          end
        end
        SS_RSP: begin
          if (rx_valid) begin
            state_ff <= SS_NEXT;
            if (op_ff == OP_VALID) begin
              if (enum_ff) begin
                active_ff[addr_ff] <= 1'b1;
              end else if (rx_data[0]) begin
                op_ff <= OP_CAT;
                state_ff <= SS_CMD;
              end
            end else if (rx_data < 8'(NUM_CAT) &&
                         (!found_ff || rx_data[3:0] < best_cat_ff)) begin
              found_ff <= 1'b1;
              best_cat_ff <= rx_data[3:0];
              chosen_addr_ff <= addr_ff;
            end
          end else if (timeout) begin
            active_ff[addr_ff] <= 1'b0;
            state_ff <= SS_NEXT;
          end
        end
        SS_NEXT: begin
          if (addr_ff == ADDR_LAST) begin
            enum_ff <= 1'b0;
            if (found_ff) begin
              op_ff <= OP_FRAME;
              addr_ff <= chosen_addr_ff;
              state_ff <= SS_CMD;
            end else begin
              state_ff <= SS_HOLD;
            end
          end else begin
            addr_ff <= addr_ff + 5'h01;
            op_ff <= OP_VALID;
            state_ff <= SS_CMD;
          end
        end
        SS_LOAD: begin
          if (rx_valid) begin
            ld_cnt_ff <= ld_cnt_ff + 9'h001;
            if (load_last) begin
              wr_half_ff <= ~wr_half_ff;
              state_ff <= SS_HOLD;
            end
          end else if (timeout) begin
            active_ff[addr_ff] <= 1'b0;
            state_ff <= SS_HOLD;
          end
        end
        default: state_ff <= SS_HOLD;
      endcase
    end
  end

  // ****************************************
  // ping-pong frame buffer
  // ****************************************
  always_ff @(posedge clock) begin
    if (state_ff == SS_LOAD && rx_valid) begin
      frame_mem[wr_half_ff][ld_cnt_ff] <= rx_data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      full_ff <= 2'h0;
    end else begin
      if (load_last) begin
        full_ff[wr_half_ff] <= 1'b1;
      end
      if (rd_last) begin
        full_ff[rd_half_ff] <= 1'b0;
      end
    end
  end

  assign push = full_ff[rd_half_ff] && f_ready;
  assign rd_last = push && rd_cnt_ff == FRAME_LAST;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rd_half_ff <= 1'b0;
      rd_cnt_ff <= 9'h000;
    end else if (push) begin
      rd_cnt_ff <= rd_last ? 9'h000 : rd_cnt_ff + 9'h001;
      if (rd_last) begin
        rd_half_ff <= ~rd_half_ff;
      end
    end
  end

  dfv_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_D)) u_fifo (
    .clock(clock), .rstn(rstn),
    .in_valid(full_ff[rd_half_ff]), .in_data(frame_mem[rd_half_ff][rd_cnt_ff]),
    .in_ready(f_ready),
    .out_valid(f_valid), .out_data(f_data), .out_ready(pop)
  );

  // ****************************************
  // serial playout
  // ****************************************
  assign tick = bit_cnt_ff == 16'(OUT_CYC - 1);
  assign pop = tick && left_ff == 4'h0;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bit_cnt_ff <= 16'h0000;
    end else begin
      bit_cnt_ff <= tick ? 16'h0000 : bit_cnt_ff + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sh_ff <= 8'h00;
      left_ff <= 4'h0;
      stream_data_ff <= 1'b1;
      stream_strobe_ff <= 1'b0;
      analog_inhibit_ff <= 1'b0;
    end else begin
      stream_strobe_ff <= 1'b0;
      if (tick) begin
        if (left_ff != 4'h0) begin
          stream_data_ff <= sh_ff[7];
          sh_ff <= {sh_ff[6:0], 1'b0};
          left_ff <= left_ff - 4'h1;
          stream_strobe_ff <= 1'b1;
        end else if (f_valid) begin
          stream_data_ff <= f_data[7];
          sh_ff <= {f_data[6:0], 1'b0};
          left_ff <= 4'h7;
          stream_strobe_ff <= 1'b1;
          analog_inhibit_ff <= 1'b1;
        end else begin
          stream_data_ff <= 1'b1;
          analog_inhibit_ff <= 1'b0;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ==== hw/dfv_shelf.sv ====
// Voter receiver shelf: grades frame headers and answers selector polls.
// Assumes frame bytes arrive from same-clock logic; bus and address switch are asynchronous.
`default_nettype none

module dfv_shelf import dfv_pkg::*; #(
  parameter int BUS_CYC = BUS_BIT_CYC
) (
  input wire logic clock,
  input wire logic rstn,
  dfv_bus_if.shelf bus,
  input wire logic [4:0] polling_address_switch,
  input wire logic sig_valid,
  input wire logic in_valid,
  input wire logic in_sof,
  input wire logic [7:0] in_data,
  output logic frame_ok_ff,
  output logic [3:0] category_ff
);
  dfv_shelf_state_t state_ff;
  logic [4:0] sw1_ff;
  logic [4:0] sw2_ff;
  logic [7:0] mem [FRAME_BYTES];
  logic [8:0] ld_cnt_ff;
  logic [6:0] errs_ff;
  logic [8:0] st_cnt_ff;
  logic txs_ff;
  logic [7:0] txd_ff;
  logic tx_busy;
  logic rx_valid;
  logic [7:0] rx_data;
  logic [8:0] idx;
  logic [3:0] hi;
  logic [6:0] nxt_errs;
  logic [6:0] scaled;
  logic [3:0] nxt_cat;
  logic mine;

  function automatic logic [3:0] pop8(input logic [7:0] v);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 8; i++) begin
      n = n + {3'h0, v[i]};
    end
    return n;
  endfunction

  // ****************************************
  // header grading
  // ****************************************
  assign idx = in_sof ? 9'h000 : ld_cnt_ff;
  assign hi = (idx < HDR_COUNT) ? idx[3:0] : 4'h0;
  assign nxt_errs = (in_sof ? 7'h00 : errs_ff) +
    ((idx < HDR_COUNT) ? {3'h0, pop8(in_data ^ HDR_PATTERN[8*(HDR_BYTES-1-hi) +: 8])} : 7'h00);
  assign scaled = nxt_errs >> CAT_SHIFT;
  assign nxt_cat = (scaled > {3'h0, CAT_WORST}) ? CAT_WORST : scaled[3:0];

  always_ff @(posedge clock) begin
    if (in_valid && idx <= FRAME_LAST) begin
      mem[idx] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ld_cnt_ff <= 9'h000;
      errs_ff <= 7'h00;
      frame_ok_ff <= 1'b0;
      category_ff <= CAT_WORST;
    end else if (in_valid && idx <= FRAME_LAST) begin
      ld_cnt_ff <= idx + 9'h001;
      errs_ff <= nxt_errs;
      if (in_sof) begin
        frame_ok_ff <= 1'b0;
      end
      if (idx == FRAME_LAST) begin
        frame_ok_ff <= sig_valid;
        category_ff <= nxt_cat;
      end
    end
  end

  // ****************************************
  // bus slave
  // ****************************************
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sw1_ff <= 5'h00;
      sw2_ff <= 5'h00;
    end else begin
      sw1_ff <= polling_address_switch;
      sw2_ff <= sw1_ff;
    end
  end

  dfv_uart_rx #(.BIT_CYC(BUS_CYC)) u_rx (
    .clock(clock), .rstn(rstn), .line(bus.cmd), .valid_ff(rx_valid), .data_ff(rx_data)
  );

  dfv_uart_tx #(.BIT_CYC(BUS_CYC)) u_tx (
    .clock(clock), .rstn(rstn), .start(txs_ff), .data(txd_ff),
    .busy_ff(tx_busy), .line_ff(bus.rsp_o), .low_ff(bus.rsp_oe)
  );

  assign mine = rx_valid && rx_data[4:0] == sw2_ff;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= RS_IDLE;
      st_cnt_ff <= 9'h000;
      txs_ff <= 1'b0;
      txd_ff <= 8'h00;
    end else begin
      txs_ff <= 1'b0;
      unique case (state_ff)
        RS_IDLE: begin
          if (mine) begin
            st_cnt_ff <= 9'h000;
            if (rx_data[7:5] == OP_VALID) begin
              txs_ff <= 1'b1;
              txd_ff <= {7'h00, frame_ok_ff};
            end else if (rx_data[7:5] == OP_CAT) begin
              txs_ff <= 1'b1;
              txd_ff <= {4'h0, category_ff};
            end else if (rx_data[7:5] == OP_FRAME) begin
              state_ff <= RS_STREAM;
            end
          end
        end
        RS_STREAM: begin
          if (!tx_busy && !txs_ff) begin
            txs_ff <= 1'b1;
            txd_ff <= mem[st_cnt_ff];
            st_cnt_ff <= st_cnt_ff + 9'h001;
            if (st_cnt_ff == FRAME_LAST) begin
              state_ff <= RS_IDLE;
            end
          end
        end
        default: state_ff <= RS_IDLE;
      endcase
    end
  end
endmodule

`default_nettype wire

// ==== test/dfv_chk.sv ====
// Concurrent checks on the first shelf bus and the selector outputs.
// Assumes one clock and asynchronous active-low reset shared with both ends.
`default_nettype none

module dfv_chk import dfv_pkg::*; #(
  parameter int BUS_CYC = 16,
  parameter int OUT_CYC = 40
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic cmd,
  input wire logic rsp_o,
  input wire logic rsp_oe,
  input wire logic rsp,
  input wire logic stream_data_ff,
  input wire logic stream_strobe_ff,
  input wire logic analog_inhibit_ff,
  input wire logic [MAX_RX-1:0] active_ff,
  input wire logic [4:0] chosen_addr_ff
);
  int gap_ff;
  int clow_ff;
  int rlow_ff;

  // cycles since last stream bit, and lengths of low runs on both lines
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      gap_ff <= 0;
      clow_ff <= 0;
      rlow_ff <= 0;
    end else begin
      gap_ff <= stream_strobe_ff ? 0 : gap_ff + 1;
      clow_ff <= cmd ? 0 : clow_ff + 1;
      rlow_ff <= rsp ? 0 : rlow_ff + 1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  sequence s_start;
    $fell(cmd);
  endsequence
  sequence s_start_held;
    !cmd [*4];
  endsequence

  chk_strobe_gap: assert property (stream_strobe_ff && $past(analog_inhibit_ff)
    |-> gap_ff == OUT_CYC - 1) else $error("stream bit spacing wrong");
  chk_data_stable: assert property (!stream_strobe_ff && analog_inhibit_ff
    |-> $stable(stream_data_ff)) else $error("stream bit changed without strobe");
  chk_inhibit_edge: assert property ($changed(analog_inhibit_ff)
    |-> stream_strobe_ff || gap_ff == OUT_CYC - 1) else $error("inhibit moved off a bit time");
  chk_cmd_start: assert property (s_start |-> s_start_held)
    else $error("command start bit too short");
  chk_cmd_bits: assert property ($rose(cmd) |-> clow_ff % BUS_CYC == 0)
    else $error("command bit time wrong");
  chk_cmd_frame: assert property (clow_ff <= 9 * BUS_CYC)
    else $error("command line low too long");
  chk_rsp_bits: assert property ($rose(rsp) |-> rlow_ff % BUS_CYC == 0)
    else $error("reply bit time wrong");
  chk_bus_turns: assert property (rsp_oe |-> !rsp_o && cmd)
    else $error("reply driven while selector talks");
  chk_chosen_active: assert property ($changed(chosen_addr_ff)
    |-> active_ff[chosen_addr_ff]) else $error("chosen address not in poll list");
endmodule

`default_nettype wire

// ==== test/tb_digital_frame_voter.sv ====
// Bench: one selector and two shelves on a shared bus, checked against a frame model.
// Assumes shortened bit times on both ends; shelf replies are wire-ANDed.
`default_nettype none

module tb_digital_frame_voter import dfv_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int BC = 4;
  localparam int OC = 10;
  localparam int WD = 90000;
  logic clock, strobe, sdata, inhibit;
  logic rstn = 1'b0, reset_button = 1'b0, kill = 1'b0;
  logic [1:0] sv = 2'h0, iv = 2'h0, isof = 2'h0;
  logic [7:0] idat [2] = '{8'h00, 8'h00};
  logic [4:0] sw [2] = '{5'h05, 5'h09};
  logic ok [2];
  logic [3:0] cat [2];
  logic [31:0] active;
  logic [4:0] chosen;
  logic [7:0] frm [2][FRAME_BYTES];
  logic bits [$];
  int ev [4] = '{20, 13, 6, 5};
  int miscompares, total_checks, n, errs, seed_v;

  dfv_bus_if bus_sel ();
  dfv_bus_if bus_sh [2] ();
  // kill masks the second shelf's reply, as if it failed
  assign bus_sel.rsp_oe = 1'b1;
  assign bus_sel.rsp_o = bus_sh[0].rsp & (bus_sh[1].rsp | kill);
  dfv_selector #(.BUS_CYC(BC), .OUT_CYC(OC), .REPLY_CYC(BC * REPLY_WAIT_BITS)) i_dfv_selector (
    .clock(clock), .rstn(rstn), .bus(bus_sel), .reset_button(reset_button),
    .stream_data_ff(sdata), .stream_strobe_ff(strobe), .analog_inhibit_ff(inhibit),
    .active_ff(active), .chosen_addr_ff(chosen));
  for (genvar g = 0; g < 2; g++) begin : g_sh
    assign bus_sh[g].cmd = bus_sel.cmd;
    dfv_shelf #(.BUS_CYC(BC)) i_dfv_shelf (.clock(clock), .rstn(rstn), .bus(bus_sh[g]),
      .polling_address_switch(sw[g]), .sig_valid(sv[g]), .in_valid(iv[g]),
      .in_sof(isof[g]), .in_data(idat[g]), .frame_ok_ff(ok[g]), .category_ff(cat[g]));
  end
  dfv_chk #(.BUS_CYC(BC), .OUT_CYC(OC)) i_dfv_chk (.clock(clock), .rstn(rstn),
    .cmd(bus_sh[0].cmd), .rsp_o(bus_sh[0].rsp_o), .rsp_oe(bus_sh[0].rsp_oe),
    .rsp(bus_sh[0].rsp), .stream_data_ff(sdata), .stream_strobe_ff(strobe),
    .analog_inhibit_ff(inhibit), .active_ff(active), .chosen_addr_ff(chosen));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    if (rstn && strobe && inhibit) bits.push_back(sdata);
  end

  // ****************************************
  // tasks
  // ****************************************
  task automatic tick();
    @(posedge clock);
    #1;
  endtask
  task automatic check(string nm, logic [31:0] e, logic [31:0] s);
    total_checks++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // header from the known pattern with e bits flipped, random payload
  task automatic load(int s, int e, logic v);
    for (int i = 0; i < FRAME_BYTES; i++) begin
      frm[s][i] = (i < HDR_BYTES) ? HDR_PATTERN[HDR_BITS - 1 - 8 * i -: 8] : 8'($urandom);
    end
    for (int k = 0; k < e; k++) frm[s][k % HDR_BYTES][k / HDR_BYTES] ^= 1'b1;
    sv[s] = v;
    for (int i = 0; i < FRAME_BYTES; i++) begin
      tick();
      iv[s] = 1'b1;
      isof[s] = (i == 0);
      idat[s] = frm[s][i];
    end
    tick();
    iv[s] = 1'b0;
    repeat (3) tick();
    check("frame_ok", 32'(v), 32'(ok[s]));
    if (v) check("category", (e / 2 > 9) ? 9 : e / 2, 32'(cat[s]));
  endtask
  // stream is MSB first, byte 0 first
  task automatic cmp(int s, int base, int cnt);
    errs = 0;
    for (int k = 0; k < cnt; k++) begin
      if (bits[base + k] !== frm[s][k / 8][7 - k % 8]) errs++;
    end
    check("stream bits", 32'h0, 32'(errs));
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed_v = $urandom(6022);
    repeat (20) @(posedge clock);
    #1 rstn = 1'b1;
    load(1, 0, 1'b0);
    foreach (ev[j]) load(1, ev[j], 1'b1);
    load(0, 4, 1'b1);
    $display("done grading");
    for (n = 0; n < 40000 && chosen !== 5'h05; n++) tick();
    check("tie choice", 32'h5, 32'(chosen));
    check("poll list", 32'h220, active);
    check("analog path", 32'h0, 32'(inhibit));
    load(1, 0, 1'b1);
    $display("done polling");
    for (n = 0; n < 80000 && bits.size() < FRAME_BITS - 400; n++) tick();
    check("next choice", 32'h9, 32'(chosen));
    kill = 1'b1;
    for (n = 0; n < 9000 && bits.size() < FRAME_BITS; n++) tick();
    cmp(0, 0, FRAME_BITS);
    check("digital path", 32'h1, 32'(inhibit));
    $display("done first frame");
    for (n = 0; n < 12000 && active[9] !== 1'b0; n++) tick();
    check("drop list", 32'h20, active);
    for (n = 0; n < 9000 && bits.size() < FRAME_BITS + 256; n++) tick();
    cmp(1, FRAME_BITS, 256);
    $display("done failure");
    kill = 1'b0;
    reset_button = 1'b1;
    repeat (4) tick();
    reset_button = 1'b0;
    for (n = 0; n < 30000 && active !== 32'h220; n++) tick();
    check("rescan list", 32'h220, active);
    $display("done rescan");
    summarize();
  end

  initial begin
    #(WD * 8);
    miscompares++;
    $display("[FAIL] watchdog expected end seen timeout");
    summarize();
  end
endmodule

`default_nettype wire
